// >>> dv/dsr_deserializer_tb.sv
`timescale 1ns/1ps
module dsr_deserializer_tb;
   import dsr_pkg::*;
   logic        ref_clk;
   logic        rst_b;
   logic        run;
   logic        pd_n;
   logic        link_clk;
   logic [3:0]  ser;
   int          cyc;
   int          errors;
   int          n_checks;
   logic [27:0] w_data;
   logic [20:0] n_data;
   logic        w_rclk, w_hs, w_vs, w_de, w_sp, w_lock, w_valid, w_pd;
   logic        n_rclk, n_hs, n_vs, n_de, n_sp;

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter feeds the wide build; the narrow build sees the first three pairs
   dsr_tx_model #(.PAIRS(4)) tx (.run_in(run), .link_clock_out(link_clk), .pairs_out(ser), .cyc_out(cyc));
   dsr_deserializer #(.PAIRS(4), .LOCK_ACQUIRE_MAX(2000)) dut (
      .ref_clk_in(ref_clk), .rst_b_in(rst_b), .link_clock_in(link_clk), .serial_pair_inputs_in(ser),
      .low_power_request_n_in(pd_n), .parallel_data_outputs_out(w_data), .recovered_output_clock_out(w_rclk),
      .hsync_out(w_hs), .vsync_out(w_vs), .display_enable_flag_out(w_de), .spare_control_bit_out(w_sp),
      .link_locked_out(w_lock), .outputs_valid_out(w_valid), .power_down_out(w_pd));
   dsr_deserializer #(.PAIRS(3), .LOCK_ACQUIRE_MAX(2000)) dut_n (
      .ref_clk_in(ref_clk), .rst_b_in(rst_b), .link_clock_in(link_clk), .serial_pair_inputs_in(ser[2:0]),
      .low_power_request_n_in(pd_n), .parallel_data_outputs_out(n_data), .recovered_output_clock_out(n_rclk),
      .hsync_out(n_hs), .vsync_out(n_vs), .display_enable_flag_out(n_de), .spare_control_bit_out(n_sp),
      .link_locked_out(), .outputs_valid_out(), .power_down_out());

   ////////////////////////////////////////////////////////////////////////////
   // Expected word of link cycle n
   function automatic logic [27:0] exp_word(input int n);
      logic [6:0] b;
      b = 7'(n * 11 + 3);
      return {b, ~b, b ^ 7'h55, b + 7'h1A} ^ 28'hB4D2E17;
   endfunction

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch t=%0t %s", $time, msg);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Bounded wait for valid output; valid without lock is never allowed
   task automatic wait_valid(input int lim);
      int i;
      i = 0;
      while (w_valid !== 1'b1 && i < lim) begin
         @(posedge ref_clk);
         #1;
         i++;
      end
      chk(w_valid === 1'b1 && w_lock === 1'b1, "no lock in time");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Every update is the word of two link cycles ago; the wide word does not move in between
   task automatic t_data(input int nupd);
      logic [27:0] prev;
      logic [27:0] e;
      logic        prev_clk;
      int          seen;
      int          i;
      prev = w_data;
      prev_clk = w_rclk;
      seen = 0;
      i = 0;
      while (seen < nupd && i < 20 * nupd) begin
         @(posedge ref_clk);
         #1;
         i++;
         if (w_rclk === 1'b1 && prev_clk === 1'b0) begin
            e = exp_word(cyc - 2);
            seen++;
            chk(w_data === e && w_valid === 1'b1, "wide word");
            chk({w_sp, w_de, w_vs, w_hs} === {e[23], e[26], e[25], e[24]}, "wide controls");
            chk(n_data === e[20:0] && n_rclk === 1'b1, "narrow word");
            chk({n_sp, n_de, n_vs, n_hs} === {1'b0, e[20], e[19], e[18]}, "narrow controls");
         end else begin
            chk(w_data === prev, "word moved off clock edge");
         end
         prev = w_data;
         prev_clk = w_rclk;
      end
      chk(seen == nupd, "too few updates");
      $display("test data done");
   endtask

   // Power-down entry time, quiet outputs, and relock before valid data
   task automatic t_power_down();
      int i;
      @(posedge ref_clk);
      pd_n <= 1'b0;
      i = 0;
      do begin
         @(posedge ref_clk);
         #1;
         i++;
      end while (w_pd !== 1'b1 && i < 100);
      chk(i <= POWER_DOWN_ENTRY_CYC, "late power down");
      repeat (16) @(posedge ref_clk);
      #1;
      chk(w_data === 28'h0000000 && w_valid === 1'b0 && w_lock === 1'b0, "power down state");
      @(posedge ref_clk);
      pd_n <= 1'b1;
      wait_valid(400);
      t_data(6);
      $display("test power down done");
   endtask

   // Transmitter loses power: clocks stop and outputs hold
   task automatic t_link_stop();
      logic [27:0] held;
      logic        rc;
      int          i;
      @(posedge ref_clk);
      run <= 1'b0;
      repeat (100) @(posedge ref_clk);
      #1;
      held = w_data;
      rc = w_rclk;
      chk(w_valid === 1'b0 && w_lock === 1'b0, "stall not flagged");
      for (int k = 0; k < 200; k++) begin
         @(posedge ref_clk);
         #1;
         chk(w_data === held && w_rclk === rc, "output moved while stopped");
      end
      @(posedge ref_clk);
      run <= 1'b1;
      i = 0;
      while (w_lock !== 1'b1 && i < 300) begin
         @(posedge ref_clk);
         #1;
         i++;
      end
      chk(w_lock === 1'b1, "no relock");
      $display("test link stop done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reference clock, 40 ns
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Watchdog well beyond the several hundred cycles the tests need
   initial begin
      #3000000;
      errors++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      rst_b = 1'b0;
      run = 1'b0;
      pd_n = 1'b1;
      errors = 0;
      n_checks = 0;
      repeat (8) @(posedge ref_clk);
      #1;
      chk(w_pd === 1'b1 && w_data === 28'h0000000 && w_valid === 1'b0, "reset state");
      @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      run <= 1'b1;
      wait_valid(300);
      t_data(12);
      t_power_down();
      t_link_stop();
      report_and_stop();
   end
endmodule

// >>> dv/dsr_tx_model.sv
`timescale 1ns/1ps
// Behavioural serialising transmitter: forwarded link clock plus data pairs
module dsr_tx_model
   import dsr_pkg::*;
#(
   parameter int PAIRS = PAIRS_WIDE
) (
   // Control from the bench
   input  wire logic        run_in,
   // Link pins
   output logic             link_clock_out,
   output logic [PAIRS-1:0] pairs_out,
   // Link cycles sent so far
   output int               cyc_out
);
   localparam real HALF_BIT_NS = 320.0 / 14.0;

   ////////////////////////////////////////////////////////////////////////////
   // Word sent in link cycle n; bench keeps its own copy of this pattern
   function automatic logic [27:0] tx_pattern(input int n);
      logic [6:0] b;
      b = 7'(n * 11 + 3);
      return {b, ~b, b ^ 7'h55, b + 7'h1A} ^ 28'hB4D2E17;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Start 15 ns ahead of a reference edge so sample points sit inside bits
   initial begin
      logic [27:0] w;
      link_clock_out = 1'b0;
      pairs_out      = '0;
      cyc_out        = 0;
      forever begin
         wait (run_in === 1'b1);
         #25;
         while (run_in === 1'b1) begin
            w = tx_pattern(cyc_out);
            link_clock_out = 1'b1;
            // 320 ns period, seven equal bits, bit k of pair p is index p*7+k
            for (int k = 0; k < 7; k++) begin
               for (int p = 0; p < PAIRS; p++) begin
                  pairs_out[p] = w[p*7+k];
               end
               #(HALF_BIT_NS);
               if (k == 3) begin
                  link_clock_out = 1'b0;
               end
               #(HALF_BIT_NS);
            end
            cyc_out++;
         end
         // Released lines must not look like the last bit, so show its inverse
         pairs_out = ~pairs_out;
      end
   end
endmodule

// >>> rtl/dsr_deserializer.sv
`timescale 1ns/1ps
module dsr_deserializer
   import dsr_pkg::*;
#(
   parameter int PAIRS            = PAIRS_WIDE,
   parameter int LOCK_ACQUIRE_MAX = LOCK_ACQUIRE_CYC
) (
   // Clock and reset
   input  wire logic                            ref_clk_in,
   input  wire logic                            rst_b_in,
   // Link pins
   input  wire logic                            link_clock_in,
   input  wire logic [PAIRS-1:0]                serial_pair_inputs_in,
   input  wire logic                            low_power_request_n_in,
   // Parallel side
   output logic [PAIRS*BITS_PER_PAIR-1:0]       parallel_data_outputs_out,
   output logic                                 recovered_output_clock_out,
   output logic                                 hsync_out,
   output logic                                 vsync_out,
   output logic                                 display_enable_flag_out,
   output logic                                 spare_control_bit_out,
   // Status
   output logic                                 link_locked_out,
   output logic                                 outputs_valid_out,
   output logic                                 power_down_out
);
   localparam int W      = PAIRS * BITS_PER_PAIR;
   localparam int SW     = PAIRS + 2;
   localparam int HS_IDX = (PAIRS == PAIRS_WIDE) ? HSYNC_IDX_WIDE : HSYNC_IDX_NARROW;
   localparam int VS_IDX = (PAIRS == PAIRS_WIDE) ? VSYNC_IDX_WIDE : VSYNC_IDX_NARROW;
   localparam int DE_IDX = (PAIRS == PAIRS_WIDE) ? DE_IDX_WIDE : DE_IDX_NARROW;
   localparam int PW     = PHASE_W + 4;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [SW-1:0]          sync_meta;
   logic [SW-1:0]          sync_s;
   wire  [PAIRS-1:0]       pair_s  = sync_s[PAIRS-1:0];
   wire                    link_s  = sync_s[PAIRS];
   wire                    lp_n_s  = sync_s[PAIRS+1];
   wire                    pd      = !lp_n_s;

   // one link clock beside the pairs
   // Clock and data share one path so their sampling delay stays matched
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync_meta <= '0;
         sync_s    <= '0;
      end else begin
         sync_meta <= {low_power_request_n_in, link_clock_in, serial_pair_inputs_in};
         sync_s    <= sync_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link clock recovery

   logic                   rise;
   logic [PHASE_W-1:0]     phase;
   logic [PHASE_W-1:0]     period;
   logic                   locked;
   logic                   stalled;

   dsr_link_mon u_mon (
      .ref_clk_in  (ref_clk_in),
      .rst_b_in    (rst_b_in),
      .pd_in       (pd),
      .link_s_in   (link_s),
      .rise_out    (rise),
      .phase_out   (phase),
      .period_out  (period),
      .locked_out  (locked),
      .stalled_out (stalled)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sample points and capture

   logic [BITS_PER_PAIR-1:0] strobe;
   logic [BITS_PER_PAIR-1:0] mask;
   logic [BITS_PER_PAIR-1:0] next_mask;
   logic [W-1:0]             word;
   logic [W-1:0]             next_word;
   logic                     pend_valid;
   logic [W-1:0]             pend_data;
   wire                      cap_en;
   wire                      word_done;
   wire  [PHASE_W-1:0]       phase_n;
   wire  [PHASE_W-1:0]       slot;

   dsr_word_if #(.W(W)) wr_if (.clk(ref_clk_in));
   dsr_word_if #(.W(W)) rd_if (.clk(ref_clk_in));

   // no capture before lock; full queue also stalls capture
   assign cap_en = locked && !(pend_valid && !wr_if.ready);

   // Slot 0 is the edge-detect cycle itself, whose synced data share the clock's delay
   assign phase_n = phase + 1'b1;
   assign slot    = rise ? '0 : phase_n;

   // bit k is sampled at (2k+1)/14 of the measured period, mid-bit
   genvar k;
   genvar p;
   generate
      for (k = 0; k < BITS_PER_PAIR; k++) begin : g_pos
         wire [PW-1:0] prod = PW'(2 * k + 1) * {4'h0, period};
         wire [PW-1:0] pos  = prod / PW'(2 * BITS_PER_PAIR);
         assign strobe[k]    = cap_en && ({4'h0, slot} == pos);
         assign next_mask[k] = rise ? strobe[k] : (mask[k] | strobe[k]);
         // bit k of pair p lands at index p*7+k
         for (p = 0; p < PAIRS; p++) begin : g_pair
            assign next_word[p*BITS_PER_PAIR+k] = strobe[k] ? pair_s[p] : word[p*BITS_PER_PAIR+k];
         end
      end
   endgenerate

   // a word is complete only when the first six points were all taken
   assign word_done = strobe[BITS_PER_PAIR-1] && (mask[BITS_PER_PAIR-2:0] == '1);

   // Capture registers
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         word <= '0;
         mask <= '0;
      end else begin
         word <= next_word;
         mask <= pd ? '0 : next_mask;
      end
   end

   // Holding stage towards the queue
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pend_valid <= 1'b0;
         pend_data  <= '0;
      end else if (pd) begin
         pend_valid <= 1'b0;
      end else if (word_done) begin
         pend_valid <= 1'b1;
         pend_data  <= next_word;
      end else if (wr_if.ready) begin
         pend_valid <= 1'b0;
      end
   end

   assign wr_if.valid = pend_valid;
   assign wr_if.data  = pend_data;

   ////////////////////////////////////////////////////////////////////////////
   // Word queue between capture and output stage

   dsr_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .flush_in   (pd),
      .wr         (wr_if.snk),
      .rd         (rd_if.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output stage

   wire out_pop  = rise && locked && rd_if.valid;
   wire out_fall = recovered_output_clock_out && (phase == (period >> 1)) && !rise;

   // a word waits for the next link edge, two periods after its first bit
   assign rd_if.ready = rise && locked;

   // data and clock move together; no edge means hold
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         parallel_data_outputs_out  <= '0;
         recovered_output_clock_out <= 1'b0;
         hsync_out                  <= 1'b0;
         vsync_out                  <= 1'b0;
         display_enable_flag_out    <= 1'b0;
         spare_control_bit_out      <= 1'b0;
      end else if (pd) begin
         parallel_data_outputs_out  <= '0;
         recovered_output_clock_out <= 1'b0;
         hsync_out                  <= 1'b0;
         vsync_out                  <= 1'b0;
         display_enable_flag_out    <= 1'b0;
         spare_control_bit_out      <= 1'b0;
      end else if (out_pop) begin
         parallel_data_outputs_out  <= rd_if.data;
         recovered_output_clock_out <= 1'b1;
         hsync_out                  <= rd_if.data[HS_IDX];
         vsync_out                  <= rd_if.data[VS_IDX];
         display_enable_flag_out    <= rd_if.data[DE_IDX];
         spare_control_bit_out      <= (PAIRS == PAIRS_WIDE) ? rd_if.data[SPARE_IDX_WIDE] : 1'b0;
      end else if (out_fall) begin
         recovered_output_clock_out <= 1'b0;
      end
   end

   // status flags; valid drops whenever lock is gone
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link_locked_out   <= 1'b0;
         outputs_valid_out <= 1'b0;
         power_down_out    <= 1'b1;
      end else begin
         link_locked_out   <= locked;
         power_down_out    <= pd;
         if (!locked || pd) outputs_valid_out <= 1'b0;
         else if (out_pop) outputs_valid_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Helper: cycles spent hunting while the link toggles
   logic [31:0] hunt_cnt;
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) hunt_cnt <= '0;
      else if (locked || pd || stalled) hunt_cnt <= '0;
      else hunt_cnt <= hunt_cnt + 1'b1;
   end

   lock_time_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      hunt_cnt < 32'(LOCK_ACQUIRE_MAX))
      else $error("lock not reached in time");

   lock_gate_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      $rose(wr_if.valid) |-> $past(locked))
      else $error("word captured without lock");

   full_word_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      $rose(wr_if.valid) |-> $past(mask) == 7'h3F)
      else $error("word pushed before seven samples");

   // data moves only with a rising output clock or when power-down clears it
   clk_update_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      $changed(parallel_data_outputs_out) |-> $rose(recovered_output_clock_out) || $past(pd))
      else $error("data changed without output clock edge");

   pd_entry_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      $fell(lp_n_s) |-> ##1 (power_down_out && !recovered_output_clock_out && !outputs_valid_out
                             && parallel_data_outputs_out == '0))
      else $error("power-down not entered");

   stall_hold_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      (stalled && !rise && !pd) |=> $stable(parallel_data_outputs_out) && $stable(recovered_output_clock_out))
      else $error("outputs moved while link clock stopped");

   invalid_lock_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      !locked |=> !outputs_valid_out)
      else $error("outputs valid without lock");

   // output clock stops with the link
   clk_stop_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      (stalled && !rise) [*2] |-> !$rose(recovered_output_clock_out))
      else $error("output clock rose on a dead link");

endmodule

// >>> rtl/dsr_fifo.sv
`timescale 1ns/1ps
module dsr_fifo
   import dsr_pkg::*;
#(
   parameter int W     = 28,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   input  wire logic flush_in,
   // Word ports
   dsr_word_if.snk   wr,
   dsr_word_if.src   rd
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wptr;
   logic [AW:0]  rptr;
   logic [AW:0]  count;
   wire          push = wr.valid && wr.ready;
   wire          pop  = rd.valid && rd.ready;

   // Honest full and empty from the pointer distance
   assign count    = wptr - rptr;
   assign wr.ready = (count != (AW+1)'(DEPTH));
   assign rd.valid = (count != '0);
   assign rd.data  = mem[rptr[AW-1:0]];

   // Pointers; flush empties the queue on power-down
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wptr <= '0;
         rptr <= '0;
      end else if (flush_in) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         wptr <= wptr + (AW+1)'(push);
         rptr <= rptr + (AW+1)'(pop);
      end
   end

   // Storage has no reset, only written on push
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= wr.data;
      end
   end

   fifo_count_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      (push && !pop && !flush_in) |=> count == $past(count) + 1'b1)
      else $error("fifo count did not grow on push");

endmodule

// >>> rtl/dsr_link_mon.sv
`timescale 1ns/1ps
module dsr_link_mon
   import dsr_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk_in,
   input  wire logic               rst_b_in,
   // Synchronised inputs
   input  wire logic               pd_in,
   input  wire logic               link_s_in,
   // Timing state
   output logic                    rise_out,
   output logic [PHASE_W-1:0]      phase_out,
   output logic [PHASE_W-1:0]      period_out,
   output logic                    locked_out,
   output logic                    stalled_out
);
   dsr_lock_e          state;
   dsr_lock_e          next_state;
   logic               link_d;
   logic [2:0]         good;
   wire [PHASE_W-1:0]  meas    = phase_out + 1'b1;
   wire [PHASE_W-1:0]  diff    = (meas > period_out) ? meas - period_out : period_out - meas;
   wire                in_rng  = (meas >= PHASE_W'(MIN_PERIOD_CYC)) && (meas <= PHASE_W'(MAX_PERIOD_CYC));
   wire                steady  = in_rng && (diff <= PHASE_W'(PERIOD_TOL));

   // Edge and stall decode
   assign rise_out    = link_s_in && !link_d;
   assign stalled_out = (phase_out >= PHASE_W'(MAX_PERIOD_CYC));
   assign locked_out  = (state == DSR_LOCKED);

   // Lock tracking
   always_comb begin
      next_state = state;
      unique case (state)
         DSR_OFF:     next_state = DSR_HUNT;
         DSR_HUNT:    if (rise_out && steady && good == 3'(LOCK_PERIODS - 1)) next_state = DSR_LOCKED;
         DSR_LOCKED:  if (stalled_out) next_state = DSR_STALLED;
                      else if (rise_out && !steady) next_state = DSR_HUNT;
         DSR_STALLED: if (rise_out) next_state = DSR_HUNT;
      endcase
      if (pd_in) next_state = DSR_OFF;
   end

   // Phase counter saturates so a dead link reads as stalled
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state      <= DSR_OFF;
         link_d     <= 1'b0;
         phase_out  <= '1;
         period_out <= '0;
         good       <= '0;
      end else begin
         state  <= next_state;
         link_d <= link_s_in;
         if (rise_out) phase_out <= '0;
         else if (!stalled_out) phase_out <= phase_out + 1'b1;
         if (rise_out) period_out <= meas;
         if (pd_in || (rise_out && !steady)) good <= '0;
         else if (rise_out && good != 3'(LOCK_PERIODS - 1)) good <= good + 1'b1;
      end
   end

   period_range_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      locked_out |-> (period_out >= PHASE_W'(MIN_PERIOD_CYC) && period_out <= PHASE_W'(MAX_PERIOD_CYC)))
      else $error("locked on a period outside the window");

endmodule

// >>> rtl/dsr_pkg.sv
package dsr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Link geometry
   localparam int PAIRS_WIDE          = 4;
   localparam int PAIRS_NARROW        = 3;
   localparam int BITS_PER_PAIR       = 7;
   localparam int COLOUR_BITS_WIDE    = 24;
   localparam int COLOUR_BITS_NARROW  = 18;

   // Control bit positions in the parallel word
   localparam int SPARE_IDX_WIDE      = 23;
   localparam int HSYNC_IDX_WIDE      = 24;
   localparam int VSYNC_IDX_WIDE      = 25;
   localparam int DE_IDX_WIDE         = 26;
   localparam int HSYNC_IDX_NARROW    = 18;
   localparam int VSYNC_IDX_NARROW    = 19;
   localparam int DE_IDX_NARROW       = 20;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int LINK_MIN_MHZ            = 20;
   localparam int LINK_MAX_MHZ            = 66;
   localparam int REF_CLK_PERIOD_NS       = 40;
   localparam int LOCK_ACQUIRE_TIME_MS    = 10;
   localparam int LOCK_ACQUIRE_CYC        = LOCK_ACQUIRE_TIME_MS * 1000000 / REF_CLK_PERIOD_NS;
   localparam int POWER_DOWN_ENTRY_TIME_NS = 1000;
   localparam int POWER_DOWN_ENTRY_CYC    = POWER_DOWN_ENTRY_TIME_NS / REF_CLK_PERIOD_NS;
   localparam int LATENCY_LINK_PERIODS    = 2;

   // Link period window in reference cycles, lock criteria
   localparam int PHASE_W        = 7;
   localparam int MIN_PERIOD_CYC = 7;
   localparam int MAX_PERIOD_CYC = 64;
   localparam int PERIOD_TOL     = 1;
   localparam int LOCK_PERIODS   = 4;
   localparam int FIFO_DEPTH     = 8;

   typedef enum logic [1:0] {DSR_OFF, DSR_HUNT, DSR_LOCKED, DSR_STALLED} dsr_lock_e;

endpackage

// >>> rtl/dsr_word_if.sv
`timescale 1ns/1ps
// One parallel word with valid/ready handshake
interface dsr_word_if #(parameter int W = 28) (input wire logic clk);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
